// [rtl/rsci_command_interpreter.sv]
// Relay scanner command interpreter
//
// Contract
// (RQ1) Begin-operation starts operation, idempotent
// (RQ2) Byte-available bytes go to command input
// (RQ3) Byte request returns next output queue byte
// (RQ4) Clear flushes interface, relays keep running
// (RQ5) Set-lock and clear-lock drive lock flag
// (RQ6) Read-protocol returns protocol word
// (RQ7) Read-status-byte returns current status byte
// (RQ8) Bus trigger steps scan when source bus
// (RQ9) Common trigger acts as word-serial trigger
// (RQ10) Abort idles scan, initiate arms it
// (RQ11) Clear-status empties events and queues
// (RQ12) Event enable register set and queried
// (RQ13) Event status query returns then clears
// (RQ14) Operation complete sets bit 0 when idle
// (RQ15) Completion query queues 1 when idle
// (RQ16) Wait-to-continue stalls until operations finish
// (RQ17) Reset restores power-up state with exceptions
// (RQ18) Service request enable set and queried
// (RQ19) Status byte query returns decimal value
// (RQ20) Self-test queues 0 pass, 1 fail
// (RQ21) Identification query queues board string
// (RQ22) Queue not empty sets bit 4, ready flag
// (RQ23) Parser errors set status and event bits
// (RQ24) Pending indicator covers relay and scan activity
`timescale 1ns/100ps

module rsci_command_interpreter (
	input  wire logic                 clk_i,
	input  wire logic                 rst_b_i,
	input  wire rsci_pkg::rsci_ws_s   ws_i,
	output logic                      ws_ans_valid_o,
	output logic [15:0]               ws_ans_o,
	output logic                      cmd_byte_valid_o,
	output logic [7:0]                cmd_byte_o,
	output logic                      parser_flush_o,
	input  wire rsci_pkg::rsci_cc_s   cc_i,
	output logic                      cc_ready_o,
	input  wire logic                 syntax_err_i,
	input  wire logic                 range_err_i,
	input  wire logic                 err_pop_i,
	input  wire logic                 relay_busy_i,
	output logic                      scan_step_o,
	output logic                      scan_armed_o,
	output logic                      dev_reset_o,
	output logic                      selftest_start_o,
	input  wire logic                 selftest_done_i,
	input  wire logic                 selftest_fail_i,
	input  wire logic [3:0]           addr_i,
	input  wire logic [7:0]           wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic [7:0]                rdata_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Value as decimal text followed by a line feed
	function automatic rsci_pkg::rsci_rep_s nr1(input logic [7:0] v);
		rsci_pkg::rsci_rep_s r;
		logic [7:0]          h;
		logic [7:0]          t;
		logic [7:0]          o;
		r = '0;
		h = rsci_pkg::CHAR_0 + v / 8'h64;
		t = rsci_pkg::CHAR_0 + (v / 8'h0a) % 8'h0a;
		o = rsci_pkg::CHAR_0 + v % 8'h0a;
		if (v >= 8'h64) begin
			r.text[31:0] = {rsci_pkg::CHAR_LF, o, t, h};
			r.len = 4'h4;
		end else if (v >= 8'h0a) begin
			r.text[23:0] = {rsci_pkg::CHAR_LF, o, t};
			r.len = 4'h3;
		end else begin
			r.text[15:0] = {rsci_pkg::CHAR_LF, o};
			r.len = 4'h2;
		end
		return r;
	endfunction : nr1

	// One character followed by a line feed
	function automatic rsci_pkg::rsci_rep_s one_char(input logic [7:0] c);
		rsci_pkg::rsci_rep_s r;
		r = '0;
		r.text[15:0] = {rsci_pkg::CHAR_LF, c};
		r.len = 4'h2;
		return r;
	endfunction : one_char

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_OPC,
		ST_WAIT_OPCQ,
		ST_WAIT_WAI,
		ST_TEST,
		ST_DRAIN
	} rsci_state_e;

	rsci_state_e         state;
	rsci_state_e         next_state;
	rsci_pkg::rsci_rep_s rep;
	rsci_pkg::rsci_rep_s rep_val;
	logic                rep_load;
	logic [7:0]          oq_mem [rsci_pkg::OQ_DEPTH];
	logic [rsci_pkg::OQ_AW:0] oq_wr;
	logic [rsci_pkg::OQ_AW:0] oq_rd;
	logic                oq_empty;
	logic                oq_full;
	logic                oq_push;
	logic                oq_pop;
	logic                ws_take;
	logic                ws_clear;
	logic                running;
	logic                lock;
	logic [1:0]          trig_src;
	logic [7:0]          ese;
	logic [7:0]          sre;
	logic [7:0]          esr;
	logic [7:0]          esr_set;
	logic [3:0]          err_cnt;
	logic [7:0]          stb;
	logic                pending;
	logic                trig_hit;
	logic                opc_set;
	logic                esr_clr;
	logic                cls;
	logic                soft_rst;
	logic                trig_cc;
	logic                abort;
	logic                arm;
	logic                ese_wr;
	logic                sre_wr;
	logic                st_start;

	////////////////////////////////////////////////////////////////////////////////
	// Status byte and shared terms

	assign ws_take  = ws_i.valid;
	assign ws_clear = ws_take && (ws_i.cmd == rsci_pkg::WS_CLEAR);
	assign oq_empty = (oq_wr == oq_rd);
	assign oq_full  = (oq_wr[rsci_pkg::OQ_AW] != oq_rd[rsci_pkg::OQ_AW]) &&
		(oq_wr[rsci_pkg::OQ_AW-1:0] == oq_rd[rsci_pkg::OQ_AW-1:0]);
	assign pending  = relay_busy_i || scan_step_o;                           // [RQ24]

	always_comb begin
		stb = 8'h00;
		stb[rsci_pkg::STB_ERQ] = (err_cnt != 4'h0);                             // [RQ23]
		stb[rsci_pkg::STB_MAV] = !oq_empty;                                     // [RQ22]
		stb[rsci_pkg::STB_ESB] = |(esr & ese);
		stb[rsci_pkg::STB_RQS] = |(stb & sre & 8'hbf);
	end

	assign cc_ready_o = (state == ST_IDLE) && !ws_clear;

	////////////////////////////////////////////////////////////////////////////////
	// Command sequencer

	always_comb begin
		next_state = state;
		rep_load   = 1'b0;
		rep_val    = '0;
		opc_set    = 1'b0;
		esr_clr    = 1'b0;
		cls        = 1'b0;
		soft_rst   = 1'b0;
		trig_cc    = 1'b0;
		abort      = 1'b0;
		arm        = 1'b0;
		ese_wr     = 1'b0;
		sre_wr     = 1'b0;
		st_start   = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (cc_i.valid && cc_ready_o) begin
					unique case (cc_i.op)
						rsci_pkg::CC_CLS: cls = 1'b1;                               // [RQ11]
						rsci_pkg::CC_ESE: ese_wr = 1'b1;                            // [RQ12]
						rsci_pkg::CC_ESE_Q: rep_val = nr1(ese);                     // [RQ12]
						rsci_pkg::CC_ESR_Q: begin
							rep_val = nr1(esr);                                     // [RQ13]
							esr_clr = 1'b1;                                         // [RQ13]
						end
						rsci_pkg::CC_IDN_Q: begin
							rep_val.text[87:0] = rsci_pkg::ID_TEXT;                 // [RQ21]
							rep_val.len = rsci_pkg::ID_LEN;
						end
						rsci_pkg::CC_OPC: next_state = ST_WAIT_OPC;                 // [RQ14]
						rsci_pkg::CC_OPC_Q: next_state = ST_WAIT_OPCQ;              // [RQ15]
						rsci_pkg::CC_RST: soft_rst = 1'b1;                          // [RQ17]
						rsci_pkg::CC_SRE: sre_wr = 1'b1;                            // [RQ18]
						rsci_pkg::CC_SRE_Q: rep_val = nr1(sre);                     // [RQ18]
						rsci_pkg::CC_STB_Q: rep_val = nr1(stb);                     // [RQ19]
						rsci_pkg::CC_TRG: trig_cc = 1'b1;                           // [RQ9]
						rsci_pkg::CC_TST_Q: begin
							st_start = 1'b1;                                        // [RQ20]
							next_state = ST_TEST;
						end
						rsci_pkg::CC_WAI: next_state = ST_WAIT_WAI;                 // [RQ16]
						rsci_pkg::CC_ABORT: abort = 1'b1;                           // [RQ10]
						rsci_pkg::CC_INIT: arm = 1'b1;                              // [RQ10]
					endcase
					rep_load = (rep_val.len != 4'h0);
					if (rep_load) begin
						next_state = ST_DRAIN;
					end
				end
			end
			ST_WAIT_OPC: begin
				if (!pending) begin
					opc_set = 1'b1;                                                 // [RQ14]
					next_state = ST_IDLE;
				end
			end
			ST_WAIT_OPCQ: begin
				if (!pending) begin
					rep_val = one_char(rsci_pkg::CHAR_0 + 8'h01);                   // [RQ15]
					rep_load = 1'b1;
					next_state = ST_DRAIN;
				end
			end
			ST_WAIT_WAI: begin
				if (!pending) begin
					next_state = ST_IDLE;                                           // [RQ16]
				end
			end
			ST_TEST: begin
				if (selftest_done_i) begin
					rep_val = one_char(rsci_pkg::CHAR_0 + {7'h00, selftest_fail_i}); // [RQ20]
					rep_load = 1'b1;
					next_state = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (rep.len == 4'h0) begin
					next_state = ST_IDLE;
				end
			end
		endcase
		if (ws_clear) begin
			next_state = ST_IDLE;                                                   // [RQ4]
			rep_load = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reply shifter feeding the output queue

	assign oq_push = (rep.len != 4'h0) && !oq_full;
	assign oq_pop  = ws_take && (ws_i.cmd == rsci_pkg::WS_BYTE_REQ) && !oq_empty;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rep <= '0;
		end else if (ws_clear || cls) begin
			rep <= '0;                                                              // [RQ4]
		end else if (rep_load) begin
			rep <= rep_val;
		end else if (oq_push) begin
			rep.text <= {8'h00, rep.text[rsci_pkg::REP_BYTES*8-1:8]};
			rep.len  <= rep.len - 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (oq_push) begin
			oq_mem[oq_wr[rsci_pkg::OQ_AW-1:0]] <= rep.text[7:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			oq_wr <= '0;
			oq_rd <= '0;
		end else if (ws_clear || cls) begin
			oq_wr <= '0;                                                            // [RQ11]
			oq_rd <= '0;
		end else begin
			if (oq_push) begin
				oq_wr <= oq_wr + 1'b1;
			end
			if (oq_pop) begin
				oq_rd <= oq_rd + 1'b1;                                              // [RQ3]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Word-serial answers and command byte path

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ws_ans_valid_o <= 1'b0;
			ws_ans_o       <= 16'h0000;
		end else begin
			ws_ans_valid_o <= 1'b0;
			if (ws_take) begin
				unique case (ws_i.cmd)
					rsci_pkg::WS_BYTE_REQ: begin
						ws_ans_valid_o <= 1'b1;
						ws_ans_o <= oq_empty ? 16'h0000 :
							{8'h00, oq_mem[oq_rd[rsci_pkg::OQ_AW-1:0]]};             // [RQ3]
					end
					rsci_pkg::WS_READ_PROTO: begin
						ws_ans_valid_o <= 1'b1;
						ws_ans_o <= rsci_pkg::PROTO_WORD;                           // [RQ6]
					end
					rsci_pkg::WS_READ_STB: begin
						ws_ans_valid_o <= 1'b1;
						ws_ans_o <= {8'h00, stb};                                   // [RQ7]
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_byte_valid_o <= 1'b0;
			cmd_byte_o       <= 8'h00;
			parser_flush_o   <= 1'b0;
		end else begin
			cmd_byte_valid_o <= ws_take && running &&
				(ws_i.cmd == rsci_pkg::WS_BYTE_AVAIL);                              // [RQ2]
			if (ws_take && (ws_i.cmd == rsci_pkg::WS_BYTE_AVAIL)) begin
				cmd_byte_o <= ws_i.data;                                            // [RQ2]
			end
			parser_flush_o <= ws_clear;                                             // [RQ4]
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			running <= 1'b0;
			lock    <= 1'b0;
		end else if (ws_take) begin
			if (ws_i.cmd == rsci_pkg::WS_BEGIN_OP) begin
				running <= 1'b1;                                                    // [RQ1]
			end
			if (ws_i.cmd == rsci_pkg::WS_SET_LOCK) begin
				lock <= 1'b1;                                                       // [RQ5]
			end else if (ws_i.cmd == rsci_pkg::WS_CLEAR_LOCK) begin
				lock <= 1'b0;                                                       // [RQ5]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Scan trigger subsystem, untouched by the word-serial clear

	assign trig_hit = ((ws_take && running && (ws_i.cmd == rsci_pkg::WS_TRIGGER)) || trig_cc) &&
		scan_armed_o && (trig_src == rsci_pkg::TRIG_SRC_BUS);                   // [RQ8] [RQ9]

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scan_armed_o <= 1'b0;
			scan_step_o  <= 1'b0;
		end else begin
			scan_step_o <= trig_hit;                                                // [RQ8]
			if (abort || soft_rst) begin
				scan_armed_o <= 1'b0;                                               // [RQ10]
			end else if (arm) begin
				scan_armed_o <= 1'b1;                                               // [RQ10]
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dev_reset_o      <= 1'b0;
			selftest_start_o <= 1'b0;
		end else begin
			dev_reset_o      <= soft_rst;                                           // [RQ17]
			selftest_start_o <= st_start;                                           // [RQ20]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Event status, enables and error count

	always_comb begin
		esr_set = 8'h00;
		esr_set[rsci_pkg::ESR_OPC] = opc_set;                                       // [RQ14]
		esr_set[rsci_pkg::ESR_EXE] = range_err_i;                                   // [RQ23]
		esr_set[rsci_pkg::ESR_CME] = syntax_err_i;                                  // [RQ23]
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			esr <= rsci_pkg::ESR_RST;
		end else begin
			esr <= ((esr_clr || cls) ? 8'h00 : esr) | esr_set;                      // [RQ11] [RQ13]
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			err_cnt <= 4'h0;
		end else if (cls) begin
			err_cnt <= {3'h0, syntax_err_i || range_err_i};                         // [RQ11]
		end else if ((syntax_err_i || range_err_i) && !err_pop_i) begin
			if (err_cnt != rsci_pkg::ERR_MAX) begin
				err_cnt <= err_cnt + 4'h1;                                          // [RQ23]
			end
		end else if (err_pop_i && !(syntax_err_i || range_err_i) && (err_cnt != 4'h0)) begin
			err_cnt <= err_cnt - 4'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ese <= rsci_pkg::ESE_RST;
			sre <= rsci_pkg::SRE_RST;
		end else begin
			if (ese_wr) begin
				ese <= cc_i.arg;                                                    // [RQ12]
			end else if (wr_i && (addr_i == rsci_pkg::REG_ESE)) begin
				ese <= wdata_i;
			end
			if (sre_wr) begin
				sre <= cc_i.arg;                                                    // [RQ18]
			end else if (wr_i && (addr_i == rsci_pkg::REG_SRE)) begin
				sre <= wdata_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register port

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			trig_src <= rsci_pkg::CTRL_RST;
		end else if (soft_rst) begin
			trig_src <= rsci_pkg::CTRL_RST;                                         // [RQ17]
		end else if (wr_i && (addr_i == rsci_pkg::REG_CTRL)) begin
			trig_src <= wdata_i[1:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			unique case (addr_i)
				rsci_pkg::REG_CTRL:   rdata_o <= {6'h00, trig_src};
				rsci_pkg::REG_ESE:    rdata_o <= ese;
				rsci_pkg::REG_SRE:    rdata_o <= sre;
				rsci_pkg::REG_STB:    rdata_o <= stb;
				rsci_pkg::REG_ESR:    rdata_o <= esr;
				rsci_pkg::REG_RESP:   rdata_o <= {5'h00, running, !oq_empty, lock}; // [RQ22]
				rsci_pkg::REG_ERRCNT: rdata_o <= {4'h0, err_cnt};
				default:              rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

endmodule : rsci_command_interpreter

// [rtl/rsci_pkg.sv]
// Shared types and constants of the relay scanner command interpreter
package rsci_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Word-serial commands from the commander
	typedef enum logic [3:0] {
		WS_BEGIN_OP,
		WS_BYTE_AVAIL,
		WS_BYTE_REQ,
		WS_CLEAR,
		WS_CLEAR_LOCK,
		WS_SET_LOCK,
		WS_READ_PROTO,
		WS_READ_STB,
		WS_TRIGGER
	} rsci_ws_e;

	typedef struct packed {
		logic            valid;
		rsci_ws_e        cmd;
		logic [7:0]      data;
	} rsci_ws_s;

	////////////////////////////////////////////////////////////////////////////////
	// Parsed common and scan commands from the text parser
	typedef enum logic [3:0] {
		CC_CLS,
		CC_ESE,
		CC_ESE_Q,
		CC_ESR_Q,
		CC_IDN_Q,
		CC_OPC,
		CC_OPC_Q,
		CC_RST,
		CC_SRE,
		CC_SRE_Q,
		CC_STB_Q,
		CC_TRG,
		CC_TST_Q,
		CC_WAI,
		CC_ABORT,
		CC_INIT
	} rsci_cc_e;

	typedef struct packed {
		logic            valid;
		rsci_cc_e        op;
		logic [7:0]      arg;
	} rsci_cc_s;

	////////////////////////////////////////////////////////////////////////////////
	// Reply text, low byte sent first
	localparam int unsigned REP_BYTES = 12;

	typedef struct packed {
		logic [REP_BYTES*8-1:0] text;
		logic [3:0]             len;
	} rsci_rep_s;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets of the plain register port
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ESE    = 4'h1;
	localparam logic [3:0] REG_SRE    = 4'h2;
	localparam logic [3:0] REG_STB    = 4'h3;
	localparam logic [3:0] REG_ESR    = 4'h4;
	localparam logic [3:0] REG_RESP   = 4'h5;
	localparam logic [3:0] REG_ERRCNT = 4'h6;

	// Field positions
	localparam int unsigned STB_ERQ   = 2;
	localparam int unsigned STB_MAV   = 4;
	localparam int unsigned STB_ESB   = 5;
	localparam int unsigned STB_RQS   = 6;
	localparam int unsigned ESR_OPC   = 0;
	localparam int unsigned ESR_EXE   = 4;
	localparam int unsigned ESR_CME   = 5;
	localparam int unsigned RESP_LOCK = 0;
	localparam int unsigned RESP_DOR  = 1;
	localparam int unsigned RESP_RUN  = 2;

	// Trigger source codes in the control register
	localparam logic [1:0] TRIG_SRC_IMM  = 2'h0;
	localparam logic [1:0] TRIG_SRC_BUS  = 2'h1;
	localparam logic [1:0] TRIG_SRC_HOLD = 2'h2;
	localparam logic [1:0] TRIG_SRC_TTL  = 2'h3;

	// Values after reset
	localparam logic [1:0] CTRL_RST   = 2'h2;
	localparam logic [7:0] ESE_RST    = 8'h00;
	localparam logic [7:0] SRE_RST    = 8'h00;
	localparam logic [7:0] ESR_RST    = 8'h00;

	// Output queue and text constants
	localparam int unsigned OQ_DEPTH  = 16;
	localparam int unsigned OQ_AW     = 4;
	localparam logic [7:0]  CHAR_0    = 8'h30;
	localparam logic [7:0]  CHAR_LF   = 8'h0a;
	localparam logic [3:0]  ERR_MAX   = 4'hf;

	// Arbitrary identification values
	localparam logic [15:0] PROTO_WORD = 16'h0008;
	localparam logic [87:0] ID_TEXT    = 88'h0a_30_2c_30_2c_31_2c_49_43_53_52;
	localparam logic [3:0]  ID_LEN     = 4'hb;

endpackage : rsci_pkg

// [verif/rsci_commander.sv]
// Commander model issuing word-serial commands
`timescale 1ns/100ps

module rsci_commander (
	input  wire logic          clk_i,
	input  wire logic [15:0]   ans_i,
	output rsci_pkg::rsci_ws_s ws_o
);
	logic [15:0] last_ans;

	initial ws_o = '0;

	// One command, answer read a cycle later
	task automatic send(input rsci_pkg::rsci_ws_e cmd, input logic [7:0] data);
		@(posedge clk_i);
		ws_o <= '{1'b1, cmd, data};
		@(posedge clk_i);
		ws_o <= '{1'b0, cmd, ~data};
		#1 last_ans = ans_i;
	endtask : send
endmodule : rsci_commander

// [verif/rsci_properties.sv]
// Concurrent checks on the command interpreter ports
`timescale 1ns/100ps

module rsci_properties (
	input wire logic               clk_i,
	input wire logic               rst_b_i,
	input wire rsci_pkg::rsci_ws_s ws_i,
	input wire logic               ws_ans_valid_o,
	input wire logic [15:0]        ws_ans_o,
	input wire logic               cmd_byte_valid_o,
	input wire logic [7:0]         cmd_byte_o,
	input wire logic               parser_flush_o,
	input wire rsci_pkg::rsci_cc_s cc_i,
	input wire logic               cc_ready_o,
	input wire logic               scan_armed_o,
	input wire logic               dev_reset_o,
	input wire logic               selftest_start_o
);
	logic ws;
	logic tk;
	assign ws = ws_i.valid;
	assign tk = cc_i.valid && cc_ready_o;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////
	a_ws_answer: assert property (ws && ws_i.cmd inside {rsci_pkg::WS_BYTE_REQ,
		rsci_pkg::WS_READ_PROTO, rsci_pkg::WS_READ_STB} |=> ws_ans_valid_o)
		else $error("word-serial answer missing");
	a_answer_cause: assert property (ws_ans_valid_o |-> $past(ws))
		else $error("answer without command");
	a_proto_word: assert property (ws && ws_i.cmd == rsci_pkg::WS_READ_PROTO
		|=> ws_ans_o == rsci_pkg::PROTO_WORD) else $error("protocol word wrong");
	a_byte_pass: assert property (cmd_byte_valid_o |->
		$past(ws && ws_i.cmd == rsci_pkg::WS_BYTE_AVAIL) && cmd_byte_o == $past(ws_i.data))
		else $error("command byte wrong");
	a_clear_flush: assert property (ws && ws_i.cmd == rsci_pkg::WS_CLEAR
		|-> !cc_ready_o ##1 parser_flush_o) else $error("clear not flushing");
	a_init_arm: assert property (tk && cc_i.op == rsci_pkg::CC_INIT |=> scan_armed_o)
		else $error("initiate not arming");
	a_abort_idle: assert property (tk && cc_i.op inside {rsci_pkg::CC_ABORT,
		rsci_pkg::CC_RST} |=> !scan_armed_o) else $error("abort not idling");
	a_reset_pulse: assert property (tk && cc_i.op == rsci_pkg::CC_RST
		|=> dev_reset_o ##1 !dev_reset_o) else $error("reset pulse wrong");
	a_test_start: assert property (tk && cc_i.op == rsci_pkg::CC_TST_Q
		|=> selftest_start_o) else $error("self test not started");
	c_opc: cover property (tk && cc_i.op == rsci_pkg::CC_OPC);
	c_disarm: cover property (scan_armed_o ##1 !scan_armed_o);
	c_flush: cover property (parser_flush_o);
endmodule : rsci_properties

bind rsci_command_interpreter rsci_properties u_props (.clk_i, .rst_b_i, .ws_i,
	.ws_ans_valid_o, .ws_ans_o, .cmd_byte_valid_o, .cmd_byte_o, .parser_flush_o,
	.cc_i, .cc_ready_o, .scan_armed_o, .dev_reset_o, .selftest_start_o);

// [verif/tb_top.sv]
// Self-checking bench of the relay scanner command interpreter
`timescale 1ns/100ps

module tb_top;
	logic               clk_i = 1'b0;
	logic               rst_b_i, syntax_err_i, range_err_i, err_pop_i, relay_busy_i;
	logic               selftest_done_i, selftest_fail_i, wr_i, rd_i;
	logic               ws_ans_valid_o, cmd_byte_valid_o, parser_flush_o, cc_ready_o;
	logic               scan_step_o, scan_armed_o, dev_reset_o, selftest_start_o;
	logic [15:0]        ws_ans_o;
	logic [7:0]         cmd_byte_o, wdata_i, rdata_o;
	logic [3:0]         addr_i;
	rsci_pkg::rsci_ws_s ws_i;
	rsci_pkg::rsci_cc_s cc_i;
	int                 err_total = 0, compares = 0, steps = 0;

	rsci_command_interpreter uut (.clk_i, .rst_b_i, .ws_i, .ws_ans_valid_o, .ws_ans_o,
		.cmd_byte_valid_o, .cmd_byte_o, .parser_flush_o, .cc_i, .cc_ready_o, .syntax_err_i,
		.range_err_i, .err_pop_i, .relay_busy_i, .scan_step_o, .scan_armed_o, .dev_reset_o,
		.selftest_start_o, .selftest_done_i, .selftest_fail_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o);
	rsci_commander cmdr (.clk_i, .ans_i(ws_ans_o), .ws_o(ws_i));

	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) if (scan_step_o === 1'b1) steps <= steps + 1;
	////////////////////////////////////////
	function automatic string dec(input int v);
		return $sformatf("%0d\n", v);
	endfunction : dec
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rr(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(16'(rdata_o), 16'(exp));
	endtask : rr
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic wrdy;
		int n = 0;
		@(negedge clk_i);
		while (cc_ready_o !== 1'b1 && n < 3000) begin
			@(negedge clk_i);
			n++;
		end
		if (n == 3000) chk(16'h0000, 16'h0001);
	endtask : wrdy
	task automatic cc(input rsci_pkg::rsci_cc_e op, input logic [7:0] arg);
		wrdy();
		@(posedge clk_i);
		cc_i <= '{1'b1, op, arg};
		@(posedge clk_i);
		cc_i <= '0;
		wrdy();
		repeat (2) @(posedge clk_i);
	endtask : cc
	task automatic rep(input string s);
		foreach (s[i]) begin
			cmdr.send(rsci_pkg::WS_BYTE_REQ, 8'h00);
			chk(cmdr.last_ans, {8'h00, s[i]});
		end
	endtask : rep
	task automatic busy_cc(input rsci_pkg::rsci_cc_e op);
		@(posedge clk_i);
		relay_busy_i <= 1'b1;
		fork
			cc(op, 8'h00);
			begin
				repeat (20) @(posedge clk_i);
				#1 chk(16'(cc_ready_o), 16'h0000);
				@(posedge clk_i);
				relay_busy_i <= 1'b0;
			end
		join
	endtask : busy_cc
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////
	// Run takes under a thousand cycles
	initial begin
		#40000;
		err_total++;
		give_verdict();
	end
	initial begin
		string s;
		logic [7:0] v [2];
		logic f;
		{cc_i, syntax_err_i, range_err_i, err_pop_i, relay_busy_i} = '0;
		{selftest_done_i, selftest_fail_i, addr_i, wdata_i, wr_i, rd_i} = '0;
		rst_b_i = 1'b0;
		void'($urandom(4614));
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 8; i++) rr(4'(i), i == 0 ? rsci_pkg::CTRL_RST : 8'h00);
		cmdr.send(rsci_pkg::WS_BEGIN_OP, 8'h00);
		cmdr.send(rsci_pkg::WS_BEGIN_OP, 8'h00);
		rr(rsci_pkg::REG_RESP, 8'h04);
		cmdr.send(rsci_pkg::WS_SET_LOCK, 8'h00);
		rr(rsci_pkg::REG_RESP, 8'h05);
		cmdr.send(rsci_pkg::WS_CLEAR_LOCK, 8'h00);
		rr(rsci_pkg::REG_RESP, 8'h04);
		v[0] = 8'($urandom);
		cmdr.send(rsci_pkg::WS_BYTE_AVAIL, v[0]);
		chk(16'(cmd_byte_o), 16'(v[0]));
		cmdr.send(rsci_pkg::WS_READ_PROTO, 8'h00);
		chk(cmdr.last_ans, rsci_pkg::PROTO_WORD);
		$display("word-serial test done");
		@(posedge clk_i);
		syntax_err_i <= 1'b1;
		@(posedge clk_i);
		syntax_err_i <= 1'b0;
		range_err_i <= 1'b1;
		@(posedge clk_i);
		range_err_i <= 1'b0;
		cmdr.send(rsci_pkg::WS_READ_STB, 8'h00);
		chk(cmdr.last_ans, 16'(1 << rsci_pkg::STB_ERQ));
		cc(rsci_pkg::CC_STB_Q, 8'h00);
		rep(dec(1 << rsci_pkg::STB_ERQ));
		cc(rsci_pkg::CC_ESR_Q, 8'h00);
		rep(dec((1 << rsci_pkg::ESR_CME) | (1 << rsci_pkg::ESR_EXE)));
		rr(rsci_pkg::REG_ESR, 8'h00);
		@(posedge clk_i);
		err_pop_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		err_pop_i <= 1'b0;
		rr(rsci_pkg::REG_STB, 8'h00);
		$display("error test done");
		for (int k = 0; k < 2; k++) begin
			v[k] = 8'($urandom);
			cc(k ? rsci_pkg::CC_SRE : rsci_pkg::CC_ESE, v[k]);
			cc(k ? rsci_pkg::CC_SRE_Q : rsci_pkg::CC_ESE_Q, 8'h00);
			rr(rsci_pkg::REG_RESP, 8'h06);
			rep(dec(v[k]));
			rr(4'(k + 1), v[k]);
		end
		busy_cc(rsci_pkg::CC_OPC);
		rr(rsci_pkg::REG_ESR, 8'h01);
		busy_cc(rsci_pkg::CC_OPC_Q);
		rep(dec(1));
		busy_cc(rsci_pkg::CC_WAI);
		cc(rsci_pkg::CC_ESE_Q, 8'h00);
		cc(rsci_pkg::CC_CLS, 8'h00);
		rr(rsci_pkg::REG_RESP, 8'h04);
		rr(rsci_pkg::REG_ESR, 8'h00);
		cc(rsci_pkg::CC_IDN_Q, 8'h00);
		s = "";
		for (int i = 0; i < rsci_pkg::ID_LEN; i++)
			s = $sformatf("%s%c", s, rsci_pkg::ID_TEXT[8*i+:8]);
		rep(s);
		$display("common test done");
		wr(rsci_pkg::REG_CTRL, 8'(rsci_pkg::TRIG_SRC_BUS));
		cc(rsci_pkg::CC_INIT, 8'h00);
		cmdr.send(rsci_pkg::WS_TRIGGER, 8'h00);
		repeat (2) @(posedge clk_i);
		chk(16'(steps), 16'h0001);
		cc(rsci_pkg::CC_TRG, 8'h00);
		chk(16'(steps), 16'h0002);
		cc(rsci_pkg::CC_SRE_Q, 8'h00);
		cmdr.send(rsci_pkg::WS_CLEAR, 8'h00);
		cmdr.send(rsci_pkg::WS_BYTE_REQ, 8'h00);
		chk(cmdr.last_ans, 16'h0000);
		chk(16'(scan_armed_o), 16'h0001);
		cc(rsci_pkg::CC_ABORT, 8'h00);
		cmdr.send(rsci_pkg::WS_TRIGGER, 8'h00);
		cc(rsci_pkg::CC_INIT, 8'h00);
		cc(rsci_pkg::CC_RST, 8'h00);
		chk(16'(steps) + 16'(scan_armed_o), 16'h0002);
		rr(rsci_pkg::REG_CTRL, 8'h02);
		rr(rsci_pkg::REG_ESE, v[0]);
		$display("trigger test done");
		f = 1'($urandom);
		fork
			cc(rsci_pkg::CC_TST_Q, 8'h00);
			begin
				repeat (10) @(posedge clk_i);
				selftest_fail_i <= f;
				selftest_done_i <= 1'b1;
				@(posedge clk_i);
				selftest_done_i <= 1'b0;
			end
		join
		rep(dec(f));
		$display("self test done");
		give_verdict();
	end
endmodule : tb_top
